// ### core/buck_sup_pkg.sv
package buck_sup_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned ZERO_CUR_DELAY_PS = 35000;
  localparam int unsigned ZERO_CUR_CYC = (ZERO_CUR_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BLANK_PS = 20000;
  localparam int unsigned BLANK_CYC = (BLANK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SS_DELAY_TICKS = 16;
  localparam int unsigned SS_STEP_TICKS = 16;
  localparam int unsigned NOLOAD_TICKS = 2;
  localparam int unsigned OC_WAIT_TICKS = 4096;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CODE = 12'h008;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_TGT_LSB = 8;
  localparam int unsigned ST_POWER_GOOD_OUTPUT_BIT = 0;
  localparam int unsigned ST_OV_BIT = 1;
  localparam int unsigned ST_UV_BIT = 2;
  localparam int unsigned ST_DRV_BIT = 3;
  localparam int unsigned ST_OVSD_BIT = 4;
  localparam int unsigned ST_STATE_LSB = 8;
  localparam int unsigned ST_REF_LSB = 16;
  localparam logic [7:0] TGT_RESET = 8'h60;
  localparam logic [1:0] MODE_SIX = 2'h0;
  localparam logic [1:0] MODE_FIVE_LO = 2'h1;
  localparam logic [1:0] MODE_FIVE_HI = 2'h2;
  localparam logic [1:0] OVSEL_TGT = 2'h0;
  localparam logic [1:0] OVSEL_FIX_LO = 2'h1;
  localparam logic [1:0] OVSEL_FIX_HI = 2'h2;
  localparam logic [1:0] OVSEL_SD = 2'h3;
  localparam logic [5:0] NOLOAD_A = 6'h3f;
  localparam logic [5:0] NOLOAD_B = 6'h3e;
  localparam logic [4:0] NOLOAD_5 = 5'h1f;
  localparam logic [5:0] CODE_RESET = 6'h3f;

  typedef enum logic [2:0] {S_SHUT, S_DELAY, S_RAMP, S_RUN, S_OCWAIT, S_NLWAIT} sup_state_t;

  function automatic logic is_noload(input logic [1:0] mode, input logic [5:0] code);
    if (mode == MODE_SIX || mode == 2'h3) begin
      return code == NOLOAD_A || code == NOLOAD_B;
    end
    return code[4:0] == NOLOAD_5;
  endfunction : is_noload

  function automatic logic last_tick(input logic [12:0] c, input int unsigned len);
    return c == 13'(len - 1);
  endfunction : last_tick
endpackage : buck_sup_pkg

// ### core/gate_deadtime.sv
module gate_deadtime
  import buck_sup_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic force_ls_i,
  input wire logic drive_i,
  input wire logic node_neg_i,
  input wire logic node_pos_i,
  input wire logic ls_low_i,
  input wire logic hs_margin_i,
  output logic hs_o,
  output logic ls_o
);
  typedef enum logic [2:0] {D_IDLE, D_LS_ON, D_LS_OFF, D_HS_ON, D_HS_OFF} dt_state_t;
  typedef struct packed {
    dt_state_t st;
    logic [3:0] cnt;
    logic [3:0] zc;
    logic hs;
    logic ls;
  } dt_t;

  dt_t q;
  dt_t n;
  logic drv;
  logic blanked;

  always_comb begin
    n = q;
    drv = drive_i && !force_ls_i;
    blanked = q.cnt < 4'(BLANK_CYC);
    n.cnt = (q.cnt == 4'hf) ? q.cnt : q.cnt + 4'h1;
    n.zc = !ls_low_i ? 4'h0 : ((q.zc == 4'hf) ? q.zc : q.zc + 4'h1);
    case (q.st)
      D_IDLE: begin
        if (en_i || force_ls_i) begin
          n.st = D_LS_ON;
        end
      end
      D_LS_ON: begin
        if (drv) begin
          n.st = D_LS_OFF;
          n.cnt = 4'h0;
          n.zc = 4'h0;
        end
      end
      D_LS_OFF: begin
        // Node edges from the falling low-side gate are ignored while blanked
        if (!drv) begin
          n.st = D_LS_ON;
        end else if (!blanked && (node_neg_i || node_pos_i)) begin
          n.st = D_HS_ON;
        end else if (q.zc >= 4'(ZERO_CUR_CYC)) begin
          n.st = D_HS_ON;
        end
      end
      D_HS_ON: begin
        if (!drv) begin
          n.st = D_HS_OFF;
        end
      end
      D_HS_OFF: begin
        if (hs_margin_i || !node_pos_i) begin
          n.st = D_LS_ON;
        end
      end
      default: n.st = D_IDLE;
    endcase
    if (!en_i && !force_ls_i) begin
      n.st = D_IDLE;
    end
    n.hs = n.st == D_HS_ON;
    n.ls = n.st == D_LS_ON;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign hs_o = q.hs;
  assign ls_o = q.ls;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  a_gates_exclusive: assert property (!(hs_o && ls_o)) else $error("both gates on");
  a_blank_hold: assert property (q.st == D_LS_OFF && blanked && q.zc < 4'(ZERO_CUR_CYC) |=> !hs_o)
    else $error("high side released inside blanking");
  a_ls_release: assert property (q.st == D_HS_OFF && hs_margin_i && (en_i || force_ls_i) |=> ls_o)
    else $error("low side not released");
endmodule : gate_deadtime

// ### core/buck_supervisor.sv
// What this block does
// - After low-side off, high side waits for switch node trip point.
// - Zero current: high side released fixed delay after low gate low.
// - Low-side falling disturbance on switch node is blanked.
// - Low side released on high-gate margin or switch node below threshold.
// - Shutdown without overvoltage puts modulator outputs in high impedance, switches off.
// - Both supplies must pass rising reset thresholds, with hysteresis.
// - Threshold enable must pass its level, with hysteresis.
// - No-load codes per mode shut down; any other code starts.
// - No-load code: two cycles, then shutdown trip level, modulation off.
// - No-load code never clears an overvoltage condition.
// - Soft-start begins the cycle all qualifications hold.
// - Sixteen-cycle delay, then one reference step per sixteen cycles.
// - Drivers held off while feedback above ramp reference.
// - Pre-charge above target: drivers enabled when soft-start ends.
// - Power-good low in shutdown, high only after soft-start.
// - Power-good low on faults and on any disable cause.
// - Undervoltage only lowers power-good; recovery at higher fraction.
// - Soft-start trip level is min of target-based and mode fixed level.
// - After soft-start only target-based trip level applies.
// - Overvoltage release margin depends on which level tripped.
// - Overvoltage forces low sides on and power-good low.
// - Overvoltage clearing resumes regulation and power-good.
// - Overcurrent: switches off, wait 4096 cycles, retry if enabled.
// - Open sense shuts down; restart from soft-start when cleared.
module buck_supervisor
  import buck_sup_pkg::*;
#(
  parameter int unsigned NPH = 2,
  parameter int unsigned OC_WAIT = OC_WAIT_TICKS
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic BIAS_SUPPLY_HI_I,
  input wire logic BIAS_SUPPLY_LO_I,
  input wire logic DRIVER_SUPPLY_HI_I,
  input wire logic DRIVER_SUPPLY_LO_I,
  input wire logic THRESHOLD_ENABLE_INPUT_HI_I,
  input wire logic THRESHOLD_ENABLE_INPUT_LO_I,
  input wire logic SWITCH_CYCLE_I,
  input wire logic FEEDBACK_NODE_ABOVE_REF_I,
  input wire logic UV_BELOW_TRIP_I,
  input wire logic UV_ABOVE_RECOVER_I,
  input wire logic OV_ABOVE_TARGET_I,
  input wire logic OV_ABOVE_FIXED_I,
  input wire logic OV_ABOVE_TARGET_REL_I,
  input wire logic OV_ABOVE_FIXED_REL_I,
  input wire logic OVERCURRENT_I,
  input wire logic LOCAL_OUTPUT_SENSE_HIGH_I,
  input wire logic [5:0] VOLTAGE_ID_CODE_I,
  input wire logic [NPH-1:0] DRIVE_I,
  input wire logic [NPH-1:0] NODE_BELOW_NEG_I,
  input wire logic [NPH-1:0] NODE_ABOVE_POS_I,
  input wire logic [NPH-1:0] LS_GATE_LOW_I,
  input wire logic [NPH-1:0] HS_MARGIN_I,
  output logic [NPH-1:0] HIGH_SIDE_GATE_O,
  output logic [NPH-1:0] LOW_SIDE_GATE_O,
  output logic MOD_HIZ_O,
  output logic POWER_GOOD_OUTPUT_O,
  output logic POWER_GOOD_OUTPUT_OE_N_O,
  output logic [7:0] REF_STEP_O,
  output logic [1:0] OV_LEVEL_SEL_O
);
  localparam int unsigned GW = 22 + 5 * NPH;

  typedef struct packed {
    logic [GW-1:0] s1;
    logic [GW-1:0] s2;
    logic sw_prev;
    logic vcc_ok;
    logic drv_ok;
    logic en_ok;
    logic [5:0] code;
    sup_state_t state;
    logic [12:0] cnt;
    logic [7:0] ref_step;
    logic drv_en;
    logic ov;
    logic ov_fix;
    logic ov_sd;
    logic uv;
    logic power_good_output;
    logic pg_low;
    logic hiz;
    logic [1:0] ov_sel;
    logic [1:0] mode;
    logic [7:0] target;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sup_t;

  sup_t q;
  sup_t n;
  logic [GW-1:0] raw;
  logic vcc_hi, vcc_lo, drv_hi, drv_lo, en_hi, en_lo;
  logic sw_s, fb_above, uv_below, uv_rec;
  logic ov_tgt, ov_fixd, ov_tgt_rel, ov_fix_rel, oc_s, open_s;
  logic [5:0] code_s;
  logic [NPH-1:0] ph_drive, ph_neg, ph_pos, ph_lsl, ph_mrg;
  logic tick, noload, kill, qual, ss, fix_en;
  logic [31:0] status;

  assign raw = {BIAS_SUPPLY_HI_I, BIAS_SUPPLY_LO_I, DRIVER_SUPPLY_HI_I, DRIVER_SUPPLY_LO_I,
                THRESHOLD_ENABLE_INPUT_HI_I, THRESHOLD_ENABLE_INPUT_LO_I, SWITCH_CYCLE_I,
                FEEDBACK_NODE_ABOVE_REF_I, UV_BELOW_TRIP_I, UV_ABOVE_RECOVER_I, OV_ABOVE_TARGET_I,
                OV_ABOVE_FIXED_I, OV_ABOVE_TARGET_REL_I, OV_ABOVE_FIXED_REL_I, OVERCURRENT_I,
                LOCAL_OUTPUT_SENSE_HIGH_I, VOLTAGE_ID_CODE_I, DRIVE_I, NODE_BELOW_NEG_I,
                NODE_ABOVE_POS_I, LS_GATE_LOW_I, HS_MARGIN_I};
  // Only the second stage is decoded; the first stage may be metastable
  assign {vcc_hi, vcc_lo, drv_hi, drv_lo, en_hi, en_lo, sw_s, fb_above, uv_below, uv_rec, ov_tgt,
          ov_fixd, ov_tgt_rel, ov_fix_rel, oc_s, open_s, code_s, ph_drive, ph_neg, ph_pos, ph_lsl,
          ph_mrg} = q.s2;

  assign tick = sw_s && !q.sw_prev;
  assign noload = is_noload(q.mode, q.code);
  assign kill = !q.vcc_ok || !q.drv_ok || !q.en_ok || open_s;
  assign qual = !kill && !noload;
  assign fix_en = q.ov_sel == OVSEL_FIX_LO || q.ov_sel == OVSEL_FIX_HI;

  always_comb begin
    n = q;
    n.s1 = raw;
    n.s2 = q.s1;
    n.sw_prev = sw_s;
    n.pg_low = 1'b0;
    n.pready = 1'b0;
    if (vcc_hi) begin
      n.vcc_ok = 1'b1;
    end else if (!vcc_lo) begin
      n.vcc_ok = 1'b0;
    end
    if (drv_hi) begin
      n.drv_ok = 1'b1;
    end else if (!drv_lo) begin
      n.drv_ok = 1'b0;
    end
    if (en_hi) begin
      n.en_ok = 1'b1;
    end else if (!en_lo) begin
      n.en_ok = 1'b0;
    end
    if (tick) begin
      n.code = code_s;
      n.cnt = q.cnt + 13'h1;
    end
    case (q.state)
      S_SHUT: begin
        n.drv_en = 1'b0;
        if (qual) begin
          n.state = S_DELAY;
          n.cnt = '0;
          n.ref_step = '0;
          n.ov_sd = 1'b0;
        end
      end
      S_DELAY: begin
        if (tick && last_tick(q.cnt, SS_DELAY_TICKS)) begin
          n.state = S_RAMP;
          n.cnt = '0;
        end
      end
      S_RAMP: begin
        if (!fb_above) begin
          n.drv_en = 1'b1;
        end
        if (tick && last_tick(q.cnt, SS_STEP_TICKS)) begin
          n.cnt = '0;
          if (q.ref_step < q.target) begin
            n.ref_step = q.ref_step + 8'h1;
          end
          // The step that reaches the target ends soft-start, no extra period
          if (n.ref_step >= q.target) begin
            n.state = S_RUN;
            n.drv_en = 1'b1;
          end
        end
      end
      S_RUN: n.drv_en = 1'b1;
      S_OCWAIT: begin
        n.drv_en = 1'b0;
        if (tick && last_tick(q.cnt, OC_WAIT)) begin
          n.cnt = '0;
          n.ref_step = '0;
          n.state = qual ? S_DELAY : S_SHUT;
        end
      end
      S_NLWAIT: begin
        // Modulation continues through the wait
        if (tick && last_tick(q.cnt, NOLOAD_TICKS)) begin
          n.state = S_SHUT;
          n.ov_sd = 1'b1;
          n.drv_en = 1'b0;
        end
      end
      default: n.state = S_SHUT;
    endcase
    if (kill) begin
      n.state = S_SHUT;
      n.drv_en = 1'b0;
    end else if (noload && q.state != S_SHUT && q.state != S_NLWAIT && q.state != S_OCWAIT) begin
      n.state = S_NLWAIT;
      n.cnt = '0;
    end else if (oc_s && (q.state == S_DELAY || q.state == S_RAMP || q.state == S_RUN)) begin
      n.state = S_OCWAIT;
      n.cnt = '0;
      n.drv_en = 1'b0;
    end
    // The no-load path never touches ov, so a clamp outlives it
    if (!q.ov) begin
      if (ov_tgt || (fix_en && ov_fixd)) begin
        n.ov = 1'b1;
        n.ov_fix = !ov_tgt;
      end
    end else if (q.ov_fix ? !ov_fix_rel : !ov_tgt_rel) begin
      n.ov = 1'b0;
    end
    ss = n.state == S_DELAY || n.state == S_RAMP;
    if (n.ov_sd) begin
      n.ov_sel = OVSEL_SD;
    end else if (ss) begin
      n.ov_sel = (q.mode == MODE_FIVE_HI) ? OVSEL_FIX_HI : OVSEL_FIX_LO;
    end else begin
      n.ov_sel = OVSEL_TGT;
    end
    if (uv_below) begin
      n.uv = 1'b1;
    end else if (uv_rec) begin
      n.uv = 1'b0;
    end
    n.power_good_output = n.state == S_RUN && !n.ov && !n.uv;
    n.hiz = n.state == S_SHUT && !n.ov;
    status = '0;
    status[ST_POWER_GOOD_OUTPUT_BIT] = q.power_good_output;
    status[ST_OV_BIT] = q.ov;
    status[ST_UV_BIT] = q.uv;
    status[ST_DRV_BIT] = q.drv_en;
    status[ST_OVSD_BIT] = q.ov_sd;
    status[ST_STATE_LSB +: 3] = q.state;
    status[ST_REF_LSB +: 8] = q.ref_step;
    if (PSEL_I && !PENABLE_I) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = '0;
      case (PADDR_I)
        REG_CTRL: begin
          n.prdata[CTRL_MODE_LSB +: 2] = q.mode;
          n.prdata[CTRL_TGT_LSB +: 8] = q.target;
        end
        REG_STATUS: n.prdata = status;
        REG_CODE: n.prdata[5:0] = q.code;
        default: n.pslverr = 1'b1;
      endcase
    end
    if (PSEL_I && PENABLE_I && q.pready && PWRITE_I && PADDR_I == REG_CTRL) begin
      if (PSTRB_I[0]) begin
        n.mode = PWDATA_I[CTRL_MODE_LSB +: 2];
      end
      if (PSTRB_I[1]) begin
        n.target = PWDATA_I[CTRL_TGT_LSB +: 8];
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      q <= '0;
      q.code <= CODE_RESET;
      q.target <= TGT_RESET;
      q.hiz <= 1'b1;
    end else if (CE_I) begin
      q <= n;
    end
  end

  for (genvar p = 0; p < NPH; p++) begin : g_phase
    gate_deadtime u_dt (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .en_i(q.drv_en && !q.hiz),
      .force_ls_i(q.ov),
      .drive_i(ph_drive[p]),
      .node_neg_i(ph_neg[p]),
      .node_pos_i(ph_pos[p]),
      .ls_low_i(ph_lsl[p]),
      .hs_margin_i(ph_mrg[p]),
      .hs_o(HIGH_SIDE_GATE_O[p]),
      .ls_o(LOW_SIDE_GATE_O[p])
    );
  end

  assign PRDATA_O = q.prdata;
  assign PREADY_O = q.pready;
  assign PSLVERR_O = q.pslverr;
  assign MOD_HIZ_O = q.hiz;
  assign POWER_GOOD_OUTPUT_O = q.pg_low;
  assign POWER_GOOD_OUTPUT_OE_N_O = q.power_good_output;
  assign REF_STEP_O = q.ref_step;
  assign OV_LEVEL_SEL_O = q.ov_sel;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I || !CE_I);

  a_start_now: assert property (q.state == S_SHUT && qual |=> q.state == S_DELAY)
    else $error("soft-start not begun");
  a_hiz_gates: assert property (MOD_HIZ_O |=> HIGH_SIDE_GATE_O == '0 && LOW_SIDE_GATE_O == '0)
    else $error("gate on while outputs floating");
  a_shut_power_good_output: assert property (q.state == S_SHUT |-> !POWER_GOOD_OUTPUT_OE_N_O)
    else $error("power good released in shutdown");
  a_power_good_output_cause: assert property (POWER_GOOD_OUTPUT_OE_N_O |-> q.state == S_RUN && !q.ov && !q.uv)
    else $error("power good released during fault");
  a_noload_wait: assert property (q.state == S_NLWAIT && tick && last_tick(q.cnt, NOLOAD_TICKS) && !kill
    |=> q.state == S_SHUT && OV_LEVEL_SEL_O == OVSEL_SD)
    else $error("no-load shutdown wrong");
  a_ramp_step: assert property (q.state == S_RAMP && tick && last_tick(q.cnt, SS_STEP_TICKS)
    && q.ref_step < q.target && !kill && !noload && !oc_s |=> q.ref_step == $past(q.ref_step) + 8'h1)
    else $error("reference step missing");
  a_drivers_off: assert property (q.state == S_DELAY || q.state == S_OCWAIT || q.state == S_SHUT
    |-> !q.drv_en)
    else $error("drivers enabled while held off");
  a_run_level: assert property (q.state == S_RUN |-> OV_LEVEL_SEL_O == OVSEL_TGT)
    else $error("fixed trip level after soft-start");
  a_ov_power_good_output: assert property ($rose(q.ov) |-> !POWER_GOOD_OUTPUT_OE_N_O)
    else $error("power good high at overvoltage");
  a_oc_retry: assert property (q.state == S_OCWAIT && tick && last_tick(q.cnt, OC_WAIT) && qual
    |=> q.state == S_DELAY)
    else $error("no retry after overcurrent wait");

  c_start: cover property (q.state == S_SHUT ##1 q.state == S_DELAY);
  c_run: cover property ($rose(q.state == S_RUN));
  c_oc: cover property ($rose(q.state == S_OCWAIT));
  c_ov: cover property ($rose(q.ov));
endmodule : buck_supervisor

// ### bench/power_stage_model.sv
module power_stage_model #(
  parameter int unsigned NPH = 2
) (
  input wire logic clk_i,
  input wire logic [NPH-1:0] hs_i,
  input wire logic [NPH-1:0] ls_i,
  output logic tick_o,
  output logic [NPH-1:0] drive_o,
  output logic [NPH-1:0] neg_o,
  output logic [NPH-1:0] pos_o,
  output logic [NPH-1:0] ls_low_o,
  output logic [NPH-1:0] margin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_q = 3'h0;
  logic [NPH-1:0] hs_q = '0;
  logic [NPH-1:0] ls_q = '0;
  logic [4*NPH-1:0] st_q = '0;
  // One switching cycle every eight clocks keeps soft-start short
  assign tick_o = cnt_q[2];
  // Drive stays high seven clocks of eight so the high side outlives blanking
  assign drive_o = {NPH{cnt_q != 3'h0}};
  assign {neg_o, pos_o, ls_low_o, margin_o} = st_q;
  always_ff @(posedge clk_i) begin
    cnt_q <= cnt_q + 3'h1;
    hs_q <= hs_i;
    ls_q <= ls_i;
    // Forward current: node goes negative once both gates are off
    st_q <= {~ls_q & ~hs_q, hs_q, ~ls_q, ~hs_q};
  end
endmodule : power_stage_model

// ### bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NPH = 2;
  localparam int TIMEOUT = 30000;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] wd; logic [31:0] rd; logic err;} row_t;
  row_t rows[7] = '{
    '{1'b0, 12'h000, 32'h0, 32'h0000_6000, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h0000_003f, 1'b0},
    '{1'b0, 12'h00c, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'h008, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h008, 32'h0, 32'h0000_003f, 1'b0},
    '{1'b1, 12'h000, 32'h0000_0200, 32'h0, 1'b0},
    '{1'b0, 12'h000, 32'h0, 32'h0000_0200, 1'b0}};
  logic [5:0] nl_code[4] = '{6'h3f, 6'h3e, 6'h1f, 6'h3f};
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, bias_hi = 0, bias_lo = 0, drv_hi = 0, drv_lo = 0, en_hi = 0, en_lo = 0;
  logic fb_above = 0, uv_below = 0, uv_rec = 1, ov_t = 0, ov_rel = 0, oc = 0, lsense = 0;
  logic ov_f = 0, ov_frel = 0;
  logic [5:0] code = 6'h3f;
  logic tick, hiz, pg, pg_oe_n;
  logic [NPH-1:0] drive, neg, pos, lsl, mar, hs, ls;
  logic [7:0] ref_step;
  logic [1:0] ovsel;
  int num_errors = 0, comparisons = 0, cyc = 0, gates_seen = 0, t0;

  buck_supervisor #(.NPH(NPH), .OC_WAIT(4)) i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .BIAS_SUPPLY_HI_I(bias_hi),
    .BIAS_SUPPLY_LO_I(bias_lo), .DRIVER_SUPPLY_HI_I(drv_hi), .DRIVER_SUPPLY_LO_I(drv_lo),
    .THRESHOLD_ENABLE_INPUT_HI_I(en_hi), .THRESHOLD_ENABLE_INPUT_LO_I(en_lo), .SWITCH_CYCLE_I(tick),
    .FEEDBACK_NODE_ABOVE_REF_I(fb_above), .UV_BELOW_TRIP_I(uv_below), .UV_ABOVE_RECOVER_I(uv_rec),
    .OV_ABOVE_TARGET_I(ov_t), .OV_ABOVE_FIXED_I(ov_f), .OV_ABOVE_TARGET_REL_I(ov_rel),
    .OV_ABOVE_FIXED_REL_I(ov_frel), .OVERCURRENT_I(oc), .LOCAL_OUTPUT_SENSE_HIGH_I(lsense),
    .VOLTAGE_ID_CODE_I(code), .DRIVE_I(drive), .NODE_BELOW_NEG_I(neg), .NODE_ABOVE_POS_I(pos),
    .LS_GATE_LOW_I(lsl), .HS_MARGIN_I(mar), .HIGH_SIDE_GATE_O(hs), .LOW_SIDE_GATE_O(ls), .MOD_HIZ_O(hiz),
    .POWER_GOOD_OUTPUT_O(pg), .POWER_GOOD_OUTPUT_OE_N_O(pg_oe_n), .REF_STEP_O(ref_step),
    .OV_LEVEL_SEL_O(ovsel));

  power_stage_model #(.NPH(NPH)) i_stage (.clk_i(clk), .hs_i(hs), .ls_i(ls), .tick_o(tick),
    .drive_o(drive), .neg_o(neg), .pos_o(pos), .ls_low_o(lsl), .margin_o(mar));

  always #2 clk = ~clk;

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  always @(posedge clk) begin
    cyc++;
    if ((hs | ls) != '0) begin
      gates_seen++;
    end
    // Both gates of one phase high would short the input rail
    if (rst_n && (hs & ls) != '0) begin
      chk(32'(hs & ls), 32'h0);
    end
    if (cyc == TIMEOUT) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the bench timeout ends a stalled access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  function automatic logic sig(input int w);
    case (w)
      0: return pg_oe_n;
      1: return hiz;
      default: return ref_step == 8'h01;
    endcase
  endfunction : sig

  // Bounded wait, then the level itself is compared
  task automatic wait_for(input int w, input logic v, input int lim);
    int k;
    k = 0;
    while (sig(w) !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk(32'(sig(w)), 32'(v));
  endtask : wait_for

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'({hiz, pg_oe_n, pg, hs, ls}), 32'h0000_0040);
    for (int i = 0; i < 7; i++) begin
      apb(rows[i].wr, rows[i].a, rows[i].wd);
      if (!rows[i].wr) begin
        chk(rd, rows[i].rd);
        chk(32'(er), 32'(rows[i].err));
      end
    end
    bias_hi <= 1'b1;
    bias_lo <= 1'b1;
    en_hi <= 1'b1;
    en_lo <= 1'b1;
    code <= 6'h05;
    repeat (300) @(posedge clk);
    chk(32'(hiz), 32'h1);
    drv_hi <= 1'b1;
    drv_lo <= 1'b1;
    fb_above <= 1'b1;
    gates_seen = 0;
    t0 = cyc;
    wait_for(2, 1'b1, 1000);
    chk(32'(gates_seen), 32'h0);
    chk(32'(ovsel), 32'h1);
    wait_for(0, 1'b1, 1000);
    chk(32'(cyc - t0 >= 384 && cyc - t0 <= 460), 32'h1);
    chk(32'(ref_step), 32'h2);
    chk(32'(ovsel), 32'h0);
    repeat (60) @(posedge clk);
    chk(32'(gates_seen > 0), 32'h1);
    fb_above <= 1'b0;
    bias_hi <= 1'b0;
    en_hi <= 1'b0;
    repeat (50) @(posedge clk);
    chk(32'({hiz, pg_oe_n}), 32'h1);
    uv_below <= 1'b1;
    uv_rec <= 1'b0;
    wait_for(0, 1'b0, 20);
    uv_below <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'({hiz, pg_oe_n}), 32'h0);
    uv_rec <= 1'b1;
    wait_for(0, 1'b1, 20);
    ov_t <= 1'b1;
    ov_rel <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'({ls, pg_oe_n}), 32'h6);
    ov_t <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'(ls), 32'h3);
    ov_rel <= 1'b0;
    wait_for(0, 1'b1, 50);
    oc <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'({hs, ls, pg_oe_n}), 32'h0);
    oc <= 1'b0;
    wait_for(0, 1'b1, 1200);
    lsense <= 1'b1;
    wait_for(1, 1'b1, 20);
    lsense <= 1'b0;
    wait_for(0, 1'b1, 1200);
    en_lo <= 1'b0;
    wait_for(1, 1'b1, 20);
    chk(32'(pg_oe_n), 32'h0);
    en_lo <= 1'b1;
    bias_lo <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'({hiz, pg_oe_n}), 32'h2);
    bias_lo <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(hiz), 32'h1);
    bias_hi <= 1'b1;
    en_hi <= 1'b1;
    wait_for(0, 1'b1, 1200);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, 32'h0000_0200 | 32'(i / 2 + i / 3));
      code <= nl_code[i];
      repeat (4) @(posedge clk);
      chk(32'(hiz), 32'h0);
      wait_for(1, 1'b1, 100);
      chk(32'({ovsel, pg_oe_n}), 32'h6);
      code <= 6'h05;
      wait_for(2, 1'b1, 1200);
      chk(32'(ovsel), (i == 3) ? 32'h2 : 32'h1);
      if (i == 3) begin
        ov_f <= 1'b1;
        ov_frel <= 1'b1;
        repeat (10) @(posedge clk);
        ov_f <= 1'b0;
        repeat (10) @(posedge clk);
        chk(32'({ls, pg_oe_n}), 32'h6);
        ov_frel <= 1'b0;
      end
      wait_for(0, 1'b1, 1200);
    end
    ov_t <= 1'b1;
    ov_rel <= 1'b1;
    repeat (10) @(posedge clk);
    code <= 6'h3f;
    repeat (80) @(posedge clk);
    chk(32'(ls), 32'h3);
    ov_t <= 1'b0;
    ov_rel <= 1'b0;
    code <= 6'h05;
    wait_for(0, 1'b1, 1200);
    stop_test();
  end
endmodule : tb_top
